// file: clk_gate_pkg.sv
// Constants for the sleep-mode clock gating block.
// Assumes a 32-bit register port addressed by byte offset within the control block.
package clk_gate_pkg;

   // ----------------------------------------------------------------
   // Register map (byte offsets from the control block base)
   // ----------------------------------------------------------------
   localparam logic [31:0] SYS_CTRL_BASE = 32'h400f_e000;
   localparam int ADDR_W = 12;
   localparam logic [11:0] RUN_CFG_OFS = 12'h060;
   localparam logic [11:0] RUN_GATE_OFS = 12'h104;
   localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
   localparam logic [11:0] DEEP_GATE_OFS = 12'h124;
   localparam logic [11:0] IRQ_STAT_OFS = 12'h200;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h204;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int UNITS = 8;
   localparam int COMPARATOR_ZERO_GATE_BIT = 24;
   localparam int GPC2_BIT = 18;
   localparam int GPC1_BIT = 17;
   localparam int GPC0_BIT = 16;
   localparam int TWOWIRE0_BIT = 12;
   localparam int SYNC0_BIT = 4;
   localparam int ASYNC1_BIT = 1;
   localparam int ASYNC0_BIT = 0;
   localparam logic [31:0] GATE_MASK = 32'h0107_1013;
   localparam int AUTO_GATE_BIT = 0;
   localparam logic [31:0] RUN_CFG_MASK = 32'h0000_0001;

   localparam int IRQ_W = 3;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_SLEEP_BIT = 1;
   localparam int IRQ_WAKE_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] GATE_RST = 32'h0000_0000;
   localparam logic [31:0] RUN_CFG_RST = 32'h0000_0000;

   typedef enum logic [2:0]
   {
      MODE_RUN = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_DEEP = 3'b100
   } pwr_mode_e;

endpackage

// file: gate_if.sv
// Interface joining the gating top with its selector and fault checker.
// Assumes all signals live on the single core clock.
`timescale 1ns/100ps
interface gate_if;
   import clk_gate_pkg::*;
   logic [UNITS-1:0] run_en;
   logic [UNITS-1:0] sleep_en;
   logic [UNITS-1:0] deep_en;
   logic auto_gate;
   pwr_mode_e mode;
   logic [UNITS-1:0] eff_en;
   logic [UNITS-1:0] acc;
   logic [UNITS-1:0] fault;
   logic [UNITS-1:0] ack;
   modport ctrl (output run_en, sleep_en, deep_en, auto_gate, mode, acc,
                 input eff_en, fault, ack);
   modport sel (input run_en, sleep_en, deep_en, auto_gate, mode, output eff_en);
   modport chk (input eff_en, acc, output fault, ack);
endinterface

// file: gate_select.sv
// Picks the live per-unit clock enable from the three gate registers.
// Assumes the mode and register values come from the same clock.
`timescale 1ns/100ps
module gate_select
   import clk_gate_pkg::*;
(
   gate_if.sel gi
);
   wire use_sleep;
   wire use_deep;

   // Sleep registers only govern once automatic gating is selected
   assign use_sleep = gi.auto_gate && (gi.mode == MODE_SLEEP);
   assign use_deep = gi.auto_gate && (gi.mode == MODE_DEEP);
   assign gi.eff_en = use_sleep ? gi.sleep_en :
                      use_deep ? gi.deep_en : gi.run_en;
endmodule

// file: gate_fault_check.sv
// Sorts each peripheral access into a normal completion or a bus fault.
// Assumes at most one access strobe per unit per cycle, same clock domain.
`timescale 1ns/100ps
module gate_fault_check
   import clk_gate_pkg::*;
(
   gate_if.chk gi
);
   // Unclocked units never complete an access normally
   assign gi.fault = gi.acc & ~gi.eff_en;
   assign gi.ack = gi.acc & gi.eff_en;
endmodule

// file: sleep_clock_gating.sv
// Overview of operation
// - A set gate bit clocks its unit; a clear bit leaves it unclocked and disabled.
// - Any access to an unclocked unit ends in a bus fault, never normally.
// - Reset clears all three gate registers, so every unit starts unclocked.
// - Separate run, sleep and deep-sleep gate registers; sleep one used only asleep.
// - Sleep gating applies only when the automatic gating bit is set.
// - Bit 24 enables the analog comparator zero clock while asleep.
// - Bits 18, 17, 16 enable general-purpose counters two, one, zero while asleep.
// - Bit 12 enables the two-wire controller zero clock while asleep.
// - Bit 4 enables the synchronous serial unit zero clock while asleep.
// - Bits 1 and 0 enable asynchronous serial units one and zero while asleep.
// - Unassigned bits are read-only zero; software preserves them on updates.
// - The sleep gate register decodes at offset 0x114 of the control block.
//
// Top of the peripheral clock gating block: gate registers, power mode tracking,
// bus fault steering and an interrupt on faults, sleep entry from run and wake back to run.
// Enables are levels for each unit's own clock gate; no clock is gated in here.
// Assumes a single-cycle register port and sleep requests from the core clock domain.
`timescale 1ns/100ps
module sleep_clock_gating
   import clk_gate_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic sleep_req_i,
   input wire logic deep_sleep_req_i,
   input wire logic [UNITS-1:0] periph_acc_i,
   output logic [UNITS-1:0] unit_clk_en_o,
   output logic [UNITS-1:0] periph_ack_o,
   output logic [UNITS-1:0] periph_fault_o,
   output logic [2:0] pwr_mode_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Unit bit positions
   // ----------------------------------------------------------------
   // Compact unit index 0..7 maps onto the sparse register layout
   function automatic int unit_pos(input int idx);
      int pos;
      pos = ASYNC0_BIT;
      case (idx)
         0: pos = ASYNC0_BIT;
         1: pos = ASYNC1_BIT;
         2: pos = SYNC0_BIT;
         3: pos = TWOWIRE0_BIT;
         4: pos = GPC0_BIT;
         5: pos = GPC1_BIT;
         6: pos = GPC2_BIT;
         7: pos = COMPARATOR_ZERO_GATE_BIT;
         default: pos = ASYNC0_BIT;
      endcase
      return pos;
   endfunction

   // Address match, used for every register of the block
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0] run_clock_config_reg;
   logic [31:0] run_clock_gate_reg;
   logic [31:0] sleep_clock_gate_reg;
   logic [31:0] deep_sleep_clock_gate_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_stat_next;
   logic [IRQ_W-1:0] irq_mask_reg;
   pwr_mode_e mode_reg;
   pwr_mode_e mode_next;
   logic [31:0] rdata_next;

   wire sel_cfg;
   wire sel_run;
   wire sel_sleep;
   wire sel_deep;
   wire sel_stat;
   wire sel_mask;
   wire wr_cfg;
   wire wr_run;
   wire wr_sleep;
   wire wr_deep;
   wire wr_stat;
   wire wr_mask;
   wire auto_gate_select;
   wire [UNITS-1:0] run_vec;
   wire [UNITS-1:0] sleep_vec;
   wire [UNITS-1:0] deep_vec;
   wire enter_sleep;
   wire leave_sleep;
   wire any_fault;
   wire [IRQ_W-1:0] irq_events;
   wire [IRQ_W-1:0] irq_clear;
   wire irq_next;
   wire [31:0] gate_wdata;
   wire [31:0] cfg_wdata;
   wire [31:0] stat_word;
   wire [31:0] mask_word;

   gate_if gi ();

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   assign sel_cfg = hit(addr_i, RUN_CFG_OFS);
   assign sel_run = hit(addr_i, RUN_GATE_OFS);
   assign sel_sleep = hit(addr_i, SLEEP_GATE_OFS);
   assign sel_deep = hit(addr_i, DEEP_GATE_OFS);
   assign sel_stat = hit(addr_i, IRQ_STAT_OFS);
   assign sel_mask = hit(addr_i, IRQ_MASK_OFS);

   assign wr_cfg = wr_i && sel_cfg;
   assign wr_run = wr_i && sel_run;
   assign wr_sleep = wr_i && sel_sleep;
   assign wr_deep = wr_i && sel_deep;
   assign wr_stat = wr_i && sel_stat;
   assign wr_mask = wr_i && sel_mask;

   // ----------------------------------------------------------------
   // Write data and readback words
   // ----------------------------------------------------------------
   // Unassigned bits are dropped once here so all three gate registers agree
   assign gate_wdata = wdata_i & GATE_MASK;
   assign cfg_wdata = wdata_i & RUN_CFG_MASK;
   // Narrow interrupt registers are zero-filled on purpose to the bus width
   assign stat_word = {{(32 - IRQ_W){1'b0}}, irq_stat_reg};
   assign mask_word = {{(32 - IRQ_W){1'b0}}, irq_mask_reg};

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Unmapped offsets and unassigned bits both read as zero
   // Read data stands for one cycle only; idle cycles return zero
   assign rdata_next = !rd_i ? 32'h0000_0000 :
                       sel_cfg ? run_clock_config_reg :
                       sel_run ? run_clock_gate_reg :
                       sel_sleep ? sleep_clock_gate_reg :
                       sel_deep ? deep_sleep_clock_gate_reg :
                       sel_stat ? stat_word :
                       sel_mask ? mask_word :
                       32'h0000_0000;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         rdata_o <= 32'h0000_0000;
      else
         rdata_o <= rdata_next;
   end

   // ----------------------------------------------------------------
   // Gate and configuration registers
   // ----------------------------------------------------------------
   // Masking on write keeps unassigned bits hard zero, so no storage is spent on them
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         run_clock_config_reg <= RUN_CFG_RST;
      else if (wr_cfg)
         run_clock_config_reg <= cfg_wdata;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         run_clock_gate_reg <= GATE_RST;
      else if (wr_run)
         run_clock_gate_reg <= gate_wdata;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         sleep_clock_gate_reg <= GATE_RST;
      else if (wr_sleep)
         sleep_clock_gate_reg <= gate_wdata;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         deep_sleep_clock_gate_reg <= GATE_RST;
      else if (wr_deep)
         deep_sleep_clock_gate_reg <= gate_wdata;
   end

   // Only the auto gating select is stored in the run configuration word
   assign auto_gate_select = run_clock_config_reg[AUTO_GATE_BIT];

   // ----------------------------------------------------------------
   // Compact per-unit enable vectors
   // ----------------------------------------------------------------
   for (genvar u = 0; u < UNITS; u++)
   begin : g_unit
      assign run_vec[u] = run_clock_gate_reg[unit_pos(u)];
      assign sleep_vec[u] = sleep_clock_gate_reg[unit_pos(u)];
      assign deep_vec[u] = deep_sleep_clock_gate_reg[unit_pos(u)];
   end

   // ----------------------------------------------------------------
   // Power mode tracking
   // ----------------------------------------------------------------
   // Deep sleep takes priority when the core raises both requests
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_RUN:
         begin
            if (deep_sleep_req_i)
               mode_next = MODE_DEEP;
            else if (sleep_req_i)
               mode_next = MODE_SLEEP;
         end
         MODE_SLEEP:
         begin
            if (deep_sleep_req_i)
               mode_next = MODE_DEEP;
            else if (!sleep_req_i)
               mode_next = MODE_RUN;
         end
         MODE_DEEP:
         begin
            if (!deep_sleep_req_i)
               mode_next = sleep_req_i ? MODE_SLEEP : MODE_RUN;
         end
         default: mode_next = MODE_RUN;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         mode_reg <= MODE_RUN;
      else
         mode_reg <= mode_next;
   end

   // Events look at the next mode so the status bit lands with the change
   assign enter_sleep = (mode_reg == MODE_RUN) && (mode_next != MODE_RUN);
   assign leave_sleep = (mode_reg != MODE_RUN) && (mode_next == MODE_RUN);

   // ----------------------------------------------------------------
   // Enable selection and fault steering
   // ----------------------------------------------------------------
   assign gi.run_en = run_vec;
   assign gi.sleep_en = sleep_vec;
   assign gi.deep_en = deep_vec;
   assign gi.auto_gate = auto_gate_select;
   assign gi.mode = mode_reg;
   assign gi.acc = periph_acc_i;

   gate_select u_select
   (
      .gi (gi.sel)
   );

   gate_fault_check u_check
   (
      .gi (gi.chk)
   );

   // Enables change only at a clock edge, so a unit never sees a runt clock
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         unit_clk_en_o <= '0;
      else
         unit_clk_en_o <= gi.eff_en;
   end

   // Answer comes one cycle after the access strobe, either ack or fault
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         periph_ack_o <= '0;
         periph_fault_o <= '0;
      end
      else
      begin
         periph_ack_o <= gi.ack;
         periph_fault_o <= gi.fault;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         // Mode output lags mode_reg by one cycle to stay a plain flop output
         pwr_mode_o <= MODE_RUN;
      else
         pwr_mode_o <= mode_reg;
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign any_fault = |gi.fault;
   assign irq_events[IRQ_FAULT_BIT] = any_fault;
   assign irq_events[IRQ_SLEEP_BIT] = enter_sleep;
   assign irq_events[IRQ_WAKE_BIT] = leave_sleep;
   assign irq_clear = wr_stat ? wdata_i[IRQ_W-1:0] : '0;

   // A new event in the clearing cycle survives the clear
   assign irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_events;
   assign irq_next = |(irq_stat_next & irq_mask_reg);

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         irq_stat_reg <= '0;
      else
         irq_stat_reg <= irq_stat_next;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         irq_mask_reg <= '0;
      else if (wr_mask)
         irq_mask_reg <= wdata_i[IRQ_W-1:0];
   end

   // Mask writes take effect one cycle late on the output; accepted for a flop-driven pin
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= irq_next;
   end

endmodule

// file: gate_asserts.sv
// Checker for the sleep clock gating top; sees only its ports.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/100ps
module gate_asserts
   import clk_gate_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic sleep_req_i,
   input wire logic deep_sleep_req_i,
   input wire logic [UNITS-1:0] periph_acc_i,
   input wire logic [UNITS-1:0] unit_clk_en_o,
   input wire logic [UNITS-1:0] periph_ack_o,
   input wire logic [UNITS-1:0] periph_fault_o,
   input wire logic [2:0] pwr_mode_o,
   input wire logic irq_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Live enable of the strobe cycle shows on unit_clk_en_o one cycle later
   a_fault_when_gated: assert property (
      periph_fault_o == ($past(periph_acc_i) & ~unit_clk_en_o))
      else $error("fault does not match gated access");
   a_ack_when_clocked: assert property (
      periph_ack_o == ($past(periph_acc_i) & unit_clk_en_o))
      else $error("ack does not match clocked access");
   a_reply_exclusive: assert property ((periph_ack_o & periph_fault_o) == 8'h00)
      else $error("ack and fault together");
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data outside read slot");
   a_reserved_zero: assert property (
      rd_i && addr_i == SLEEP_GATE_OFS |=> (rdata_o & ~GATE_MASK) == 32'h0)
      else $error("reserved gate bits read nonzero");
   a_gate_readback: assert property (
      (wr_i && addr_i == SLEEP_GATE_OFS) ##1 !wr_i ##1 (rd_i && addr_i == SLEEP_GATE_OFS)
      |=> rdata_o == ($past(wdata_i, 3) & GATE_MASK))
      else $error("sleep gate readback wrong");
   a_mode_onehot: assert property ($onehot(pwr_mode_o))
      else $error("power mode not one-hot");
   a_sleep_mode: assert property (
      (sleep_req_i && !deep_sleep_req_i) [*4] |-> pwr_mode_o == 3'h2)
      else $error("sleep mode not reached");
   a_deep_mode: assert property (deep_sleep_req_i [*4] |-> pwr_mode_o == 3'h4)
      else $error("deep sleep mode not reached");
endmodule

bind sleep_clock_gating gate_asserts u_gate_asserts (.core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o),
   .sleep_req_i(sleep_req_i), .deep_sleep_req_i(deep_sleep_req_i), .periph_acc_i(periph_acc_i),
   .unit_clk_en_o(unit_clk_en_o), .periph_ack_o(periph_ack_o), .periph_fault_o(periph_fault_o),
   .pwr_mode_o(pwr_mode_o), .irq_o(irq_o));

// file: periph_model.sv
// Peripheral side: pulses one unit's access strobe and reports the reply.
// Assumes the reply comes exactly one cycle after the strobe.
`timescale 1ns/100ps
module periph_model
   import clk_gate_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [2:0] unit_i,
   input wire logic [UNITS-1:0] ack_i,
   input wire logic [UNITS-1:0] fault_i,
   output logic [UNITS-1:0] acc_o,
   output logic done_o,
   output logic ok_o,
   output logic flt_o
);
   logic [2:0] unit_reg;
   logic [1:0] phase_reg;
   always_ff @(posedge clk_i)
   begin
      acc_o <= '0;
      done_o <= 1'b0;
      if (rst_i)
         phase_reg <= 2'h0;
      else if (start_i)
      begin
         acc_o <= UNITS'(1) << unit_i;
         unit_reg <= unit_i;
         phase_reg <= 2'h1;
      end
      else if (phase_reg == 2'h1)
         phase_reg <= 2'h2;
      else if (phase_reg == 2'h2)
      begin
         // Neither or both replies leave ok and flt unequal to any legal pair
         ok_o <= ack_i[unit_reg] & ~fault_i[unit_reg];
         flt_o <= fault_i[unit_reg] & ~ack_i[unit_reg];
         done_o <= 1'b1;
         phase_reg <= 2'h0;
      end
   end
endmodule

// file: tb.sv
// Self-checking bench for the sleep clock gating top.
// Assumes the register port answers one cycle after a strobe.
`timescale 1ns/100ps
module tb;
   import clk_gate_pkg::*;
   logic core_clk_i, sys_rst_i, wr_i, rd_i, sleep_req_i, deep_sleep_req_i;
   logic start, done, ok_m, flt_m;
   logic [11:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [2:0] unit, pwr_mode_o;
   logic [UNITS-1:0] acc, en, ack, flt;
   logic irq_o;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   localparam int BITPOS [UNITS] = '{ASYNC0_BIT, ASYNC1_BIT, SYNC0_BIT, TWOWIRE0_BIT,
      GPC0_BIT, GPC1_BIT, GPC2_BIT, COMPARATOR_ZERO_GATE_BIT};

   sleep_clock_gating u_sleep_clock_gating (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sleep_req_i(sleep_req_i), .deep_sleep_req_i(deep_sleep_req_i), .periph_acc_i(acc),
      .unit_clk_en_o(en), .periph_ack_o(ack), .periph_fault_o(flt), .pwr_mode_o(pwr_mode_o),
      .irq_o(irq_o));
   periph_model u_periph_model (.clk_i(core_clk_i), .rst_i(sys_rst_i), .start_i(start),
      .unit_i(unit), .ack_i(ack), .fault_i(flt), .acc_o(acc), .done_o(done), .ok_o(ok_m),
      .flt_o(flt_m));

   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Ceiling well above the roughly 160 cycles the sequence needs
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Ends on an edge, so the next drive is on an edge; reads see last edge's values
   task automatic settle;
      repeat (4) @(posedge core_clk_i);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
      @(posedge core_clk_i);
   endtask

   task automatic access(input int u, input logic ok);
      int n = 0;
      unit <= 3'(u);
      start <= 1'b1;
      @(posedge core_clk_i);
      start <= 1'b0;
      while (n < 8 && done !== 1'b1)
      begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      chk({30'h0, ok_m, flt_m}, {30'h0, ok, ~ok});
      @(posedge core_clk_i);
   endtask

   task automatic t_reset;
      chk({24'h0, en}, 32'h0);
      chk({29'h0, pwr_mode_o}, 32'h1);
      rd(SLEEP_GATE_OFS, GATE_RST);
      rd(RUN_GATE_OFS, 32'h0);
      rd(DEEP_GATE_OFS, 32'h0);
      rd(RUN_CFG_OFS, RUN_CFG_RST);
   endtask

   task automatic t_bitmap;
      for (int u = 0; u < UNITS; u++)
      begin
         wr(SLEEP_GATE_OFS, ~GATE_MASK | (32'h1 << BITPOS[u]));
         rd(SLEEP_GATE_OFS, 32'h1 << BITPOS[u]);
      end
      wr(12'h118, 32'hffff_ffff);
      rd(12'h118, 32'h0);
      rd(SLEEP_GATE_OFS, 32'h0100_0000);
   endtask

   task automatic t_sleep;
      wr(RUN_GATE_OFS, 32'h0000_0010);
      wr(RUN_CFG_OFS, 32'h1);
      wr(SLEEP_GATE_OFS, 32'h0100_0001);
      wr(DEEP_GATE_OFS, 32'h0000_1000);
      settle();
      chk({24'h0, en}, 32'h04);
      sleep_req_i <= 1'b1;
      settle();
      chk({24'h0, en}, 32'h81);
      access(0, 1'b1);
      access(7, 1'b1);
      access(2, 1'b0);
      deep_sleep_req_i <= 1'b1;
      settle();
      chk({24'h0, en}, 32'h08);
      deep_sleep_req_i <= 1'b0;
      sleep_req_i <= 1'b0;
      settle();
      chk({24'h0, en}, 32'h04);
      access(2, 1'b1);
      wr(RUN_CFG_OFS, 32'h0);
      sleep_req_i <= 1'b1;
      settle();
      chk({24'h0, en}, 32'h04);
      sleep_req_i <= 1'b0;
      settle();
   endtask

   task automatic t_irq;
      rd(IRQ_STAT_OFS, 32'h7);
      wr(IRQ_STAT_OFS, 32'h7);
      wr(IRQ_MASK_OFS, 32'h1 << IRQ_FAULT_BIT);
      access(1, 1'b0);
      settle();
      chk({31'h0, irq_o}, 32'h1);
      rd(IRQ_STAT_OFS, 32'h1);
      wr(IRQ_MASK_OFS, 32'h0);
      settle();
      chk({31'h0, irq_o}, 32'h0);
      wr(IRQ_MASK_OFS, 32'h1);
      wr(IRQ_STAT_OFS, 32'h1);
      settle();
      chk({31'h0, irq_o}, 32'h0);
      rd(IRQ_STAT_OFS, 32'h0);
   endtask

   // A fault landing in the same cycle as its clear must stay set
   task automatic t_race;
      unit <= 3'h1;
      start <= 1'b1;
      @(posedge core_clk_i);
      start <= 1'b0;
      addr_i <= IRQ_STAT_OFS;
      wdata_i <= 32'h1;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      chk({31'h0, flt_m}, 32'h1);
      rd(IRQ_STAT_OFS, 32'h1);
   endtask

   // Reset in mid-run clears registers that were written
   task automatic t_rerst;
      wr(SLEEP_GATE_OFS, GATE_MASK);
      wr(RUN_GATE_OFS, GATE_MASK);
      settle();
      chk({24'h0, en}, 32'hff);
      sys_rst_i <= 1'b1;
      settle();
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      chk({24'h0, en}, 32'h0);
      chk({29'h0, pwr_mode_o}, 32'h1);
      rd(SLEEP_GATE_OFS, GATE_RST);
      rd(RUN_GATE_OFS, 32'h0);
   endtask

   initial
   begin
      sys_rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 12'h000;
      wdata_i = 32'h0;
      sleep_req_i = 1'b0;
      deep_sleep_req_i = 1'b0;
      start = 1'b0;
      unit = 3'h0;
      repeat (4) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      t_reset();
      t_bitmap();
      t_sleep();
      t_irq();
      t_race();
      t_rerst();
      print_verdict();
   end
endmodule
